/* design/sdrct_map.svh */
// timing counts and field positions for the sdram command timing block
`ifndef SDRCT_MAP_SVH
`define SDRCT_MAP_SVH
`define SDRCT_CLK_NS 50
`define SDRCT_TRC_NS 63
`define SDRCT_TRAS_NS 42
`define SDRCT_TRAS_MAX_NS 100000
`define SDRCT_TRP_NS 15
`define SDRCT_TRCD_NS 15
`define SDRCT_TRRD_NS 14
`define SDRCT_TXSR_NS 70
`define SDRCT_TCKA_NS 3
`define SDRCT_TRC_CYC ((`SDRCT_TRC_NS + `SDRCT_CLK_NS - 1) / `SDRCT_CLK_NS)
`define SDRCT_TRAS_CYC ((`SDRCT_TRAS_NS + `SDRCT_CLK_NS - 1) / `SDRCT_CLK_NS)
`define SDRCT_TRAS_MAX_CYC (`SDRCT_TRAS_MAX_NS / `SDRCT_CLK_NS)
`define SDRCT_TRP_CYC ((`SDRCT_TRP_NS + `SDRCT_CLK_NS - 1) / `SDRCT_CLK_NS)
`define SDRCT_TRCD_CYC ((`SDRCT_TRCD_NS + `SDRCT_CLK_NS - 1) / `SDRCT_CLK_NS)
`define SDRCT_TRRD_CYC ((`SDRCT_TRRD_NS + `SDRCT_CLK_NS - 1) / `SDRCT_CLK_NS)
`define SDRCT_TXSR_CYC ((`SDRCT_TXSR_NS + `SDRCT_CLK_NS - 1) / `SDRCT_CLK_NS)
`define SDRCT_TCKA_CYC (1 + (`SDRCT_TCKA_NS + `SDRCT_CLK_NS - 1) / `SDRCT_CLK_NS)
`define SDRCT_TDAL_CL3 5
`define SDRCT_TDAL_CL2 4
`define SDRCT_TRDL_CYC 2
`define SDRCT_TMRD_CYC 2
`define SDRCT_PRECHARGE_TO_OUTPUT_RELEASE_CL3 3
`define SDRCT_PRECHARGE_TO_OUTPUT_RELEASE_CL2 2
`define SDRCT_TDQZ_CYC 2
`define SDRCT_INIT_US 200
`define SDRCT_INIT_CYC (`SDRCT_INIT_US * 1000 / `SDRCT_CLK_NS)
`define SDRCT_REF_MS 64
`define SDRCT_REF_ROWS 4096
`define SDRCT_REFI_CYC (`SDRCT_REF_MS * 1000000 / `SDRCT_REF_ROWS / `SDRCT_CLK_NS)
`define SDRCT_INIT_REFS 2
`define SDRCT_MODE_CL3 12'h030
`define SDRCT_MODE_CL2 12'h020
`define SDRCT_MODE_CL_LSB 4
`define SDRCT_MODE_BL_MASK 12'h007
`define SDRCT_AP_BIT 10
`endif

/* design/sdrct_pkg.sv */
// types for the sdram command timing block
package sdrct_pkg;
	typedef enum logic [3:0] {
		SDRCT_CMD_NOP = 4'h0,
		SDRCT_CMD_ACT = 4'h1,
		SDRCT_CMD_RD = 4'h2,
		SDRCT_CMD_WR = 4'h3,
		SDRCT_CMD_PRE = 4'h4,
		SDRCT_CMD_REF = 4'h5,
		SDRCT_CMD_MRS = 4'h6,
		SDRCT_CMD_BST = 4'h7,
		SDRCT_CMD_SREF = 4'h8
	} sdrct_cmd_e;
	typedef logic [15:0] sdrct_word_t;
endpackage : sdrct_pkg

/* design/sdrct_if.sv */
// link between sdram controller and sdram device model
`timescale 1ns/1ps
`default_nettype none
interface sdrct_if;
	logic cke;
	sdrct_pkg::sdrct_cmd_e cmd;
	logic bank_select_bit0;
	logic bank_select_bit1;
	logic [11:0] addr;
	logic [1:0] dqm;
	sdrct_pkg::sdrct_word_t dq_ctl;
	logic dq_ctl_oe;
	sdrct_pkg::sdrct_word_t dq_dev;
	logic dq_dev_oe;
	sdrct_pkg::sdrct_word_t dq;
	assign dq = dq_ctl_oe ? dq_ctl : (dq_dev_oe ? dq_dev : 16'h0000);
	modport ctl (output cke, cmd, bank_select_bit0, bank_select_bit1, addr, dqm,
		dq_ctl, dq_ctl_oe, input dq);
	modport dev (input cke, cmd, bank_select_bit0, bank_select_bit1, addr, dqm,
		output dq_dev, dq_dev_oe, input dq);
endinterface : sdrct_if
`default_nettype wire

/* design/sdrct_buf2.sv */
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module sdrct_buf2 #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_reg [2];
	logic [1:0] count_reg;
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	logic [1:0] count_next;
	logic ready_reg;
	assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
	assign in_ready = ready_reg;
	assign out_valid = (count_reg != 2'h0);
	assign out_data = mem_reg[rd_ptr_reg];
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= 2'h0;
			ready_reg <= 1'b1;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			ready_reg <= (count_next != 2'h2);
			if (push) wr_ptr_reg <= ~wr_ptr_reg;
			if (pop) rd_ptr_reg <= ~rd_ptr_reg;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push) mem_reg[wr_ptr_reg] <= in_data;
	end
endmodule : sdrct_buf2
`default_nettype wire

/* design/sdrct_dev.sv */
// sdram device end: clock enable, data mask and read release behaviour
`timescale 1ns/1ps
`default_nettype none
`include "sdrct_map.svh"
module sdrct_dev (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// link
	sdrct_if.dev lnk,
	// user side: write words captured, read words supplied
	output logic wr_valid,
	output logic [15:0] wr_data,
	output logic [13:0] wr_addr,
	output logic [1:0] wr_bank,
	input wire logic [15:0] rd_word,
	output logic powered_down
);
	// ******************************
	// clock enable
	// ******************************
	logic cke_d_reg;
	logic active_reg;
	logic cl3_reg;
	logic bl_one_reg;
	logic [2:0] rd_pipe_reg;
	logic [1:0] dqm_pipe_reg;
	logic [1:0] roh_reg;
	logic [11:0] row_reg [4];
	logic wr_burst_reg;
	logic [7:0] col_reg;
	logic [1:0] bank_reg;
	wire [1:0] bank_in = {lnk.bank_select_bit1, lnk.bank_select_bit0};
	// registered cke: commands drop on the edge cke is low, and are taken again one cycle after cke returns high
	assign active_reg = cke_d_reg;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) cke_d_reg <= 1'b1;
		else cke_d_reg <= lnk.cke;
	end
	wire take = active_reg && lnk.cke;
	wire is_wr = take && (lnk.cmd == sdrct_pkg::SDRCT_CMD_WR);
	wire is_rd = take && (lnk.cmd == sdrct_pkg::SDRCT_CMD_RD);
	wire is_pre = take && (lnk.cmd == sdrct_pkg::SDRCT_CMD_PRE);
	wire is_stop = take && (lnk.cmd == sdrct_pkg::SDRCT_CMD_BST);
	// ******************************
	// command decode
	// ******************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cl3_reg <= 1'b1;
			bl_one_reg <= 1'b1;
			wr_burst_reg <= 1'b0;
			col_reg <= 8'h00;
			bank_reg <= 2'h0;
			rd_pipe_reg <= 3'h0;
			dqm_pipe_reg <= 2'h0;
			roh_reg <= 2'h0;
			wr_valid <= 1'b0;
			wr_data <= 16'h0000;
			wr_addr <= 14'h0000;
			wr_bank <= 2'h0;
			powered_down <= 1'b0;
		end else begin
			powered_down <= ~lnk.cke;
			if (take && lnk.cmd == sdrct_pkg::SDRCT_CMD_MRS) begin
				cl3_reg <= lnk.addr[`SDRCT_MODE_CL_LSB] == 1'b1;
				bl_one_reg <= (lnk.addr & `SDRCT_MODE_BL_MASK) == 12'h000;
			end
			if (is_wr) begin
				// single-word bursts take no further words on the following nops
				wr_burst_reg <= !bl_one_reg;
				col_reg <= lnk.addr[7:0] + 8'h01;
				bank_reg <= bank_in;
			end else if (is_rd || is_pre || is_stop) begin
				wr_burst_reg <= 1'b0;
			end else if (take && wr_burst_reg) begin
				col_reg <= col_reg + 8'h01;
			end
			// first word taken on the command edge itself
			wr_valid <= (is_wr || (take && wr_burst_reg && lnk.cmd == sdrct_pkg::SDRCT_CMD_NOP))
				&& (lnk.dqm == 2'h0);
			wr_data <= lnk.dq;
			wr_addr <= {row_reg[is_wr ? bank_in : bank_reg][5:0], is_wr ? lnk.addr[7:0] : col_reg};
			wr_bank <= is_wr ? bank_in : bank_reg;
			rd_pipe_reg <= {rd_pipe_reg[1:0], is_rd};
			dqm_pipe_reg <= {dqm_pipe_reg[0], |lnk.dqm};
			if (is_pre && |rd_pipe_reg)
				roh_reg <= cl3_reg ? 2'(`SDRCT_PRECHARGE_TO_OUTPUT_RELEASE_CL3) : 2'(`SDRCT_PRECHARGE_TO_OUTPUT_RELEASE_CL2);
			else if (roh_reg != 2'h0)
				roh_reg <= roh_reg - 2'h1;
		end
	end
	// open row per bank
	always_ff @(posedge clk_sys) begin
		if (take && lnk.cmd == sdrct_pkg::SDRCT_CMD_ACT)
			row_reg[bank_in] <= lnk.addr;
	end
	// ******************************
	// read data drive
	// ******************************
	logic drive_reg;
	wire rd_due = cl3_reg ? rd_pipe_reg[2] : rd_pipe_reg[1];
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) drive_reg <= 1'b0;
		else drive_reg <= (rd_due || roh_reg > 2'h1) && !dqm_pipe_reg[1];
	end
	assign lnk.dq_dev_oe = drive_reg;
	assign lnk.dq_dev = rd_word;
endmodule : sdrct_dev
`default_nettype wire

/* design/sdrct_ctl.sv */
// sdram controller end: sequences commands under the documented spacing
// How it works
// - same-bank activates and refreshes spaced by row cycle
// - precharge between min and max after activate
// - precharge to activate waits precharge time
// - activate to column command waits row delay
// - activates to different banks spaced apart
// - self-refresh exit waits before activate
// - refresh all rows every 64 ms
// - column commands may issue every cycle
// - device drops commands on the edge cke is sampled low
// - device resumes one cycle after cke high
// - cke rise allows one clock plus 3 ns
// - write mask acts with zero latency
// - read mask floats outputs two cycles later
// - first write word rides the write command
// - burst stop one cycle after last word
// - new column command one cycle after data
// - precharge three cycles after last write word
// - mode load waits two cycles before activate
// - interrupted read drives latency-dependent extra cycles
// - wait 200 us before first command
// - bank bits, row and column from address
// - two refreshes before loading mode register
`timescale 1ns/1ps
`default_nettype none
`include "sdrct_map.svh"
module sdrct_ctl #(
	parameter int INIT_CYC = `SDRCT_INIT_CYC,
	parameter int REFI_CYC = `SDRCT_REFI_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// link
	sdrct_if.ctl lnk,
	// write request stream
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [15:0] req_data,
	input wire logic [21:0] req_addr,
	// power control
	input wire logic sleep_req,
	// status
	output logic init_done
);
	typedef enum logic [7:0] {
		SDRCT_ST_WAIT = 8'h01,
		SDRCT_ST_PALL = 8'h02,
		SDRCT_ST_IREF = 8'h04,
		SDRCT_ST_MODE = 8'h08,
		SDRCT_ST_IDLE = 8'h10,
		SDRCT_ST_ROW = 8'h20,
		SDRCT_ST_SLEEP = 8'h40,
		SDRCT_ST_WAKE = 8'h80
	} sdrct_state_e;
	// ******************************
	// helpers
	// ******************************
	function automatic logic [15:0] cyc16(input int n);
		cyc16 = (n < 1) ? 16'h0001 : 16'(n);
	endfunction : cyc16
	sdrct_state_e state_reg;
	sdrct_state_e state_next;
	logic [17:0] wait_reg;
	logic [15:0] refi_reg;
	logic ref_due_reg;
	logic [1:0] iref_reg;
	logic [15:0] trc_reg;
	logic [15:0] tras_reg;
	logic [15:0] trp_reg;
	logic [15:0] trcd_reg;
	logic [15:0] twr_reg;
	logic [15:0] tmrd_reg;
	logic [15:0] txsr_reg;
	logic [17:0] open_reg;
	logic [1:0] bank_reg;
	logic [11:0] row_reg;
	logic sleep_s1_reg;
	logic sleep_s2_reg;
	// ******************************
	// data buffer
	// ******************************
	logic bf_valid;
	logic bf_ready;
	logic [37:0] bf_data;
	sdrct_buf2 #(.WIDTH(38)) u_buf (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data({req_addr, req_data}),
		.out_valid(bf_valid),
		.out_ready(bf_ready),
		.out_data(bf_data)
	);
	wire [1:0] q_bank = bf_data[37:36];
	wire [11:0] q_row = bf_data[35:24];
	wire [7:0] q_col = bf_data[23:16];
	// ******************************
	// decisions
	// ******************************
	wire row_hit = (state_reg == SDRCT_ST_ROW) && (q_bank == bank_reg) && (q_row == row_reg);
	wire can_act = (trc_reg == 0) && (trp_reg == 0) && (tmrd_reg == 0) && (txsr_reg == 0);
	wire can_pre = (tras_reg == 0) && (twr_reg == 0);
	wire must_close = (open_reg == 0) || ref_due_reg || sleep_s2_reg;
	wire do_write = bf_valid && row_hit && (trcd_reg == 0) && !must_close;
	wire do_act = (state_reg == SDRCT_ST_IDLE) && bf_valid && can_act && !ref_due_reg
		&& !sleep_s2_reg;
	wire do_pre_row = (state_reg == SDRCT_ST_ROW) && can_pre && (must_close || (bf_valid && !row_hit));
	wire do_ref = (state_reg == SDRCT_ST_IDLE) && ref_due_reg && can_act;
	wire do_sleep = (state_reg == SDRCT_ST_IDLE) && sleep_s2_reg && !ref_due_reg && can_act;
	assign bf_ready = do_write;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SDRCT_ST_WAIT: if (wait_reg == 0) state_next = SDRCT_ST_PALL;
			SDRCT_ST_PALL: state_next = SDRCT_ST_IREF;
			SDRCT_ST_IREF: if (iref_reg == 2'(`SDRCT_INIT_REFS) && trc_reg == 0)
				state_next = SDRCT_ST_MODE;
			SDRCT_ST_MODE: state_next = SDRCT_ST_IDLE;
			SDRCT_ST_IDLE: begin
				if (do_sleep) state_next = SDRCT_ST_SLEEP;
				else if (do_act) state_next = SDRCT_ST_ROW;
			end
			SDRCT_ST_ROW: if (do_pre_row) state_next = SDRCT_ST_IDLE;
			SDRCT_ST_SLEEP: if (!sleep_s2_reg) state_next = SDRCT_ST_WAKE;
			SDRCT_ST_WAKE: if (wait_reg == 0) state_next = SDRCT_ST_IDLE;
			default: state_next = SDRCT_ST_WAIT;
		endcase
	end
	wire iref_go = (state_reg == SDRCT_ST_IREF) && (iref_reg != 2'(`SDRCT_INIT_REFS)) && trc_reg == 0;
	wire pall_go = state_reg == SDRCT_ST_PALL;
	wire any_act = do_act;
	wire any_ref = do_ref || iref_go;
	wire any_pre = do_pre_row || pall_go;
	// ******************************
	// timers
	// ******************************
	function automatic logic [15:0] tick(input logic [15:0] v);
		tick = (v == 0) ? 16'h0000 : v - 16'h0001;
	endfunction : tick
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= SDRCT_ST_WAIT;
			wait_reg <= 18'(INIT_CYC);
			refi_reg <= 16'h0000;
			ref_due_reg <= 1'b0;
			iref_reg <= 2'h0;
			trc_reg <= 16'h0000;
			tras_reg <= 16'h0000;
			trp_reg <= 16'h0000;
			trcd_reg <= 16'h0000;
			twr_reg <= 16'h0000;
			tmrd_reg <= 16'h0000;
			txsr_reg <= 16'h0000;
			open_reg <= 18'h00000;
			bank_reg <= 2'h0;
			row_reg <= 12'h000;
			sleep_s1_reg <= 1'b0;
			sleep_s2_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sleep_s1_reg <= sleep_req;
			sleep_s2_reg <= sleep_s1_reg;
			if (state_reg == SDRCT_ST_SLEEP && !sleep_s2_reg)
				wait_reg <= 18'(`SDRCT_TCKA_CYC);
			else if (wait_reg != 0)
				wait_reg <= wait_reg - 18'h00001;
			if (refi_reg == 0) begin
				refi_reg <= 16'(REFI_CYC - 1);
				ref_due_reg <= init_done;
			end else begin
				refi_reg <= refi_reg - 16'h0001;
				if (do_ref) ref_due_reg <= 1'b0;
			end
			if (iref_go) iref_reg <= iref_reg + 2'h1;
			// nanosecond limits are rounded up to whole clocks
			trc_reg <= any_ref || any_act ? cyc16(`SDRCT_TRC_CYC) - 16'h0001 : tick(trc_reg);
			tras_reg <= any_act ? cyc16(`SDRCT_TRAS_CYC) - 16'h0001 : tick(tras_reg);
			trp_reg <= any_pre ? cyc16(`SDRCT_TRP_CYC) - 16'h0001 : tick(trp_reg);
			trcd_reg <= any_act ? cyc16(`SDRCT_TRCD_CYC) - 16'h0001 : tick(trcd_reg);
			twr_reg <= do_write ? 16'(`SDRCT_TRDL_CYC) : tick(twr_reg);
			tmrd_reg <= state_reg == SDRCT_ST_MODE ? 16'(`SDRCT_TMRD_CYC - 1) : tick(tmrd_reg);
			txsr_reg <= state_reg == SDRCT_ST_WAKE ? cyc16(`SDRCT_TXSR_CYC) : tick(txsr_reg);
			if (do_act) begin
				open_reg <= 18'(`SDRCT_TRAS_MAX_CYC - 1);
				bank_reg <= q_bank;
				row_reg <= q_row;
			end else if (open_reg != 0) begin
				open_reg <= open_reg - 18'h00001;
			end
		end
	end
	// ******************************
	// pins
	// ******************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lnk.cke <= 1'b1;
			lnk.cmd <= sdrct_pkg::SDRCT_CMD_NOP;
			lnk.addr <= 12'h000;
			lnk.bank_select_bit0 <= 1'b0;
			lnk.bank_select_bit1 <= 1'b0;
			lnk.dqm <= 2'h3;
			lnk.dq_ctl <= 16'h0000;
			lnk.dq_ctl_oe <= 1'b0;
			init_done <= 1'b0;
		end else begin
			init_done <= (state_reg == SDRCT_ST_IDLE) || init_done;
			lnk.cke <= !(state_next == SDRCT_ST_SLEEP);
			lnk.dqm <= (state_reg == SDRCT_ST_WAIT) ? 2'h3 : 2'h0;
			lnk.dq_ctl <= bf_data[15:0];
			lnk.dq_ctl_oe <= do_write;
			lnk.bank_select_bit0 <= do_write ? q_bank[0] : (do_act ? q_bank[0] : bank_reg[0]);
			lnk.bank_select_bit1 <= do_write ? q_bank[1] : (do_act ? q_bank[1] : bank_reg[1]);
			if (do_write) begin
				lnk.cmd <= sdrct_pkg::SDRCT_CMD_WR;
				lnk.addr <= {4'h0, q_col};
			end else if (any_act) begin
				lnk.cmd <= sdrct_pkg::SDRCT_CMD_ACT;
				lnk.addr <= q_row;
			end else if (any_pre) begin
				lnk.cmd <= sdrct_pkg::SDRCT_CMD_PRE;
				lnk.addr <= pall_go ? 12'h400 : 12'h000;
			end else if (any_ref || do_sleep) begin
				lnk.cmd <= do_sleep ? sdrct_pkg::SDRCT_CMD_SREF : sdrct_pkg::SDRCT_CMD_REF;
			end else if (state_reg == SDRCT_ST_MODE) begin
				lnk.cmd <= sdrct_pkg::SDRCT_CMD_MRS;
				lnk.addr <= `SDRCT_MODE_CL3;
			end else begin
				lnk.cmd <= sdrct_pkg::SDRCT_CMD_NOP;
			end
		end
	end
endmodule : sdrct_ctl
`default_nettype wire

/* verification/sdrct_properties.sv */
// checker of command spacing and data timing on the sdram link
`timescale 1ns/1ps
`default_nettype none
module sdrct_properties #(
	parameter int INIT_CYC = 4,
	parameter int REFI_CYC = 40
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// link signals
	input wire logic cke,
	input wire logic [3:0] cmd,
	input wire logic bank_select_bit0,
	input wire logic bank_select_bit1,
	input wire logic [11:0] addr,
	input wire logic [1:0] dqm,
	input wire logic [15:0] dq_ctl,
	input wire logic dq_ctl_oe,
	input wire logic [15:0] dq_dev,
	input wire logic dq_dev_oe,
	input wire logic [15:0] dq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// ****************************************
	// decoded commands and helper counters
	// ****************************************
	wire logic is_act = (cmd == sdrct_pkg::SDRCT_CMD_ACT);
	wire logic is_ref = (cmd == sdrct_pkg::SDRCT_CMD_REF);
	wire logic is_mrs = (cmd == sdrct_pkg::SDRCT_CMD_MRS);
	wire logic is_wr = (cmd == sdrct_pkg::SDRCT_CMD_WR);
	wire logic [1:0] bank_now = {bank_select_bit1, bank_select_bit0};
	int cyc_cnt;
	int gap_cnt;
	logic [1:0] ref_cnt;
	logic mrs_seen;
	// power-up cycles, refreshes before the first mode load, refresh gap
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cyc_cnt <= 0;
			ref_cnt <= 2'h0;
			mrs_seen <= 1'b0;
			gap_cnt <= 0;
		end else begin
			if (cyc_cnt < INIT_CYC) cyc_cnt <= cyc_cnt + 1;
			if (is_ref && ref_cnt != 2'h3) ref_cnt <= ref_cnt + 2'h1;
			if (is_mrs) mrs_seen <= 1'b1;
			gap_cnt <= (is_ref || !cke) ? 0 : gap_cnt + 1;
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	a_act_same_bank: assert property (is_act |=> !(is_act && bank_now == $past(bank_now)))
		else $error("same bank activated on consecutive cycles");
	a_ref_spacing: assert property (is_ref |=> !is_ref)
		else $error("refresh commands too close");
	a_wr_to_pre: assert property (is_wr |=> cmd != sdrct_pkg::SDRCT_CMD_PRE)
		else $error("precharge too soon after write data");
	a_mode_settle: assert property (is_mrs |=> !(is_act || is_ref))
		else $error("activate or refresh too soon after mode load");
	a_wake_quiet: assert property ($rose(cke) |-> (cmd == sdrct_pkg::SDRCT_CMD_NOP) [*2])
		else $error("command too soon after clock enable rise");
	a_exit_no_act: assert property ($rose(cke) |-> (!is_act) [*3])
		else $error("activate too soon after self refresh exit");
	a_wr_data_rides: assert property (is_wr |-> dq_ctl_oe && !dq_dev_oe && dq == dq_ctl)
		else $error("write data not on the bus with the write command");
	a_oe_only_wr: assert property (dq_ctl_oe |-> is_wr)
		else $error("controller drives data outside a write");
	a_init_refs: assert property (is_mrs |-> ref_cnt[1])
		else $error("mode load before two refreshes");
	a_power_wait: assert property (!(cmd == sdrct_pkg::SDRCT_CMD_NOP) |-> cyc_cnt >= INIT_CYC - 1)
		else $error("command issued during power-up delay");
	a_refresh_due: assert property (mrs_seen && cke |-> gap_cnt <= 2 * REFI_CYC)
		else $error("refresh interval overrun");
	c_write: cover property (is_wr);
	c_refresh: cover property (is_ref);
	c_mode: cover property (is_mrs);
	c_wake: cover property ($rose(cke));
endmodule : sdrct_properties
`default_nettype wire

/* verification/sdram_command_timing_test.sv */
// self-checking bench joining the controller and device ends
`timescale 1ns/1ps
`default_nettype none
module sdram_command_timing_test;
	// ****************************************
	// clock, instances and monitors
	// ****************************************
	logic clk_sys, reset_n, req_valid, req_ready, sleep_req, init_done;
	logic wr_valid, powered_down, stall_seen;
	logic [15:0] req_data, wr_data;
	logic [21:0] req_addr;
	logic [13:0] wr_addr;
	logic [1:0] wr_bank;
	logic [31:0] got_q[$];
	int n_fail, cmp_count, ref_count;
	sdrct_if lnk();
	sdrct_ctl #(.INIT_CYC(4), .REFI_CYC(40)) i_sdrct_ctl (.clk_sys(clk_sys), .reset_n(reset_n),
		.lnk(lnk), .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
		.req_addr(req_addr), .sleep_req(sleep_req), .init_done(init_done));
	sdrct_dev i_sdrct_dev (.clk_sys(clk_sys), .reset_n(reset_n), .lnk(lnk),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_addr(wr_addr), .wr_bank(wr_bank),
		.rd_word(16'hC35A), .powered_down(powered_down));
	sdrct_properties #(.INIT_CYC(4), .REFI_CYC(40)) i_sdrct_properties (.clk_sys(clk_sys),
		.reset_n(reset_n), .cke(lnk.cke), .cmd(lnk.cmd), .bank_select_bit0(lnk.bank_select_bit0),
		.bank_select_bit1(lnk.bank_select_bit1), .addr(lnk.addr), .dqm(lnk.dqm),
		.dq_ctl(lnk.dq_ctl), .dq_ctl_oe(lnk.dq_ctl_oe), .dq_dev(lnk.dq_dev),
		.dq_dev_oe(lnk.dq_dev_oe), .dq(lnk.dq));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (wr_valid === 1'b1) got_q.push_back({wr_bank, wr_addr, wr_data});
		if (lnk.cmd === sdrct_pkg::SDRCT_CMD_REF) ref_count++;
	end
	// ****************************************
	// compare and closing tasks
	// ****************************************
	task automatic tally_and_finish();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : cmp_val
	task automatic cmp_flag(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : cmp_flag
	task automatic timed_out();
		n_fail++;
		$display("[FAIL] %0t wait ran out", $time);
		tally_and_finish();
	endtask : timed_out
	// ****************************************
	// scenarios
	// ****************************************
	task automatic do_reset();
		int n;
		int base;
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		cmp_flag(init_done, 1'b0);
		cmp_flag(lnk.cke, 1'b1);
		cmp_flag(powered_down, 1'b0);
		cmp_val(32'(lnk.dqm), 32'h3);
		reset_n <= 1'b1;
		base = ref_count;
		for (n = 0; n < 500 && init_done !== 1'b1; n++) @(negedge clk_sys);
		if (n == 500) timed_out();
		cmp_flag(ref_count - base >= 2, 1'b1);
	endtask : do_reset
	task automatic send_word(input logic [21:0] a, input logic [15:0] d);
		int n;
		req_addr <= a;
		req_data <= d;
		req_valid <= 1'b1;
		n = 0;
		// ready seen at the negedge still stands at the next rising edge
		@(negedge clk_sys);
		while (req_ready !== 1'b1 && n < 200) begin
			stall_seen = 1'b1;
			@(negedge clk_sys);
			n++;
		end
		if (n == 200) timed_out();
		@(posedge clk_sys);
	endtask : send_word
	// back-to-back writes over all banks, pairs share a row, top edge row and both edge columns
	task automatic t_burst();
		int i;
		int n;
		logic [21:0] a;
		logic [15:0] d;
		logic [31:0] exp_q[$];
		got_q.delete();
		stall_seen = 1'b0;
		@(posedge clk_sys);
		for (i = 0; i < 8; i++) begin
			a = {2'(i / 2), 12'hFFF - 12'((i / 2) * 12'h111), 8'hFF - 8'(i * 51)};
			d = 16'hA5A5 ^ 16'(i * 16'h1357);
			exp_q.push_back({a[21:20], a[13:8], a[7:0], d});
			send_word(a, d);
		end
		req_valid <= 1'b0;
		for (n = 0; n < 300 && got_q.size() < 8; n++) @(negedge clk_sys);
		if (n == 300) timed_out();
		cmp_flag(stall_seen, 1'b1);
		for (i = 0; i < 8; i++) cmp_val(got_q[i], exp_q[i]);
		repeat (4) @(negedge clk_sys);
		cmp_val(32'(got_q.size()), 32'h8);
	endtask : t_burst
	task automatic t_refresh();
		int base;
		base = ref_count;
		repeat (200) @(posedge clk_sys);
		cmp_flag(ref_count - base >= 4, 1'b1);
	endtask : t_refresh
	task automatic t_sleep();
		int n;
		int base;
		@(posedge clk_sys);
		sleep_req <= 1'b1;
		for (n = 0; n < 100 && lnk.cke !== 1'b0; n++) @(negedge clk_sys);
		if (n == 100) timed_out();
		cmp_flag(powered_down, 1'b0);
		@(negedge clk_sys);
		cmp_flag(powered_down, 1'b1);
		base = ref_count;
		repeat (20) @(negedge clk_sys);
		cmp_flag(ref_count == base, 1'b1);
		@(posedge clk_sys);
		sleep_req <= 1'b0;
		for (n = 0; n < 100 && lnk.cke !== 1'b1; n++) @(negedge clk_sys);
		if (n == 100) timed_out();
		cmp_flag(powered_down, 1'b1);
		@(negedge clk_sys);
		cmp_flag(powered_down, 1'b0);
	endtask : t_sleep
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		n_fail = 0;
		cmp_count = 0;
		ref_count = 0;
		reset_n = 1'b0;
		req_valid = 1'b0;
		req_data = 16'h0000;
		req_addr = 22'h000000;
		sleep_req = 1'b0;
		stall_seen = 1'b0;
		do_reset();
		t_burst();
		t_refresh();
		t_sleep();
		t_burst();
		do_reset();
		t_burst();
		tally_and_finish();
	end
endmodule : sdram_command_timing_test
`default_nettype wire
